// ### logic/vga_fe_consts.svh
// address map, field and count constants for the display front end
`ifndef VGA_FE_CONSTS_SVH
`define VGA_FE_CONSTS_SVH
`define WIN_ALL_LO 20'ha0000
`define WIN_ALL_HI 20'hbffff
`define WIN_EGA_LO 20'ha0000
`define WIN_EGA_HI 20'haffff
`define WIN_MDA_LO 20'hb0000
`define WIN_MDA_HI 20'hb7fff
`define WIN_CGA_LO 20'hb8000
`define WIN_CGA_HI 20'hbffff
`define IO_LO 10'h3b0
`define IO_HI 10'h3df
`define IO_MONO_HI 10'h3bf
`define IO_COLOR_LO 10'h3d0
`define MAP_ALL 2'h0
`define MAP_EGA 2'h1
`define MAP_MDA 2'h2
`define MAP_CGA 2'h3
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_DWORD 2'h2
`define BE_EVEN 4'h5
`define BE_ODD 4'ha
`define BE_NONE 4'h0
`endif

// ### logic/vga_fe_pkg.sv
// types shared by the display front end
package vga_fe_pkg;
  typedef struct packed {
    logic is_io;
    logic write;
    logic [1:0] size;
    logic [19:0] addr;
    logic [31:0] wdata;
  } host_req_t;
  typedef struct packed {
    logic [1:0] map_sel;
    logic alt_write;
    logic quad_write;
    logic alt_read;
    logic [1:0] read_plane;
    logic [3:0] plane_write_mask;
    logic page_select_bit;
    logic color_io;
  } fe_cfg_t;
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } fb_cmd_t;
endpackage

// ### logic/vga_front_end.sv
// host-to-frame-buffer front end of the legacy display
`timescale 1ns/1ps
`include "vga_fe_consts.svh"
module vga_front_end (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire vga_fe_pkg::host_req_t req,
  input wire vga_fe_pkg::fe_cfg_t cfg_in,
  input wire logic fb_rvalid,
  input wire logic [31:0] fb_rdata,
  output logic req_ready,
  output logic fb_valid,
  output vga_fe_pkg::fb_cmd_t fb_cmd,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [31:0] rd_pixels,
  output logic io_hit,
  output logic io_is_data,
  output logic [9:0] io_addr,
  output logic [7:0] io_index,
  output logic sysmem_pass,
  output logic ext_bus_start,
  output logic system_mgmt_interrupt_pin
);
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_byte = 3'b010,
    st_wait = 3'b100
  } fe_state_t;

  fe_state_t state;
  vga_fe_pkg::fe_cfg_t cfg;
  logic [19:0] cur_addr;
  logic [31:0] wbytes;
  logic [1:0] left;
  logic cur_write;
  logic taken;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic win_hit(input logic [19:0] a,
                                   input logic [1:0] m);
    unique case (m)
      `MAP_EGA: win_hit = a >= `WIN_EGA_LO && a <= `WIN_EGA_HI;
      `MAP_MDA: win_hit = a >= `WIN_MDA_LO && a <= `WIN_MDA_HI;
      `MAP_CGA: win_hit = a >= `WIN_CGA_LO && a <= `WIN_CGA_HI;
      default: win_hit = a >= `WIN_ALL_LO && a <= `WIN_ALL_HI;
    endcase
  endfunction

  // mono block answers only in mono setup, color block only in color
  function automatic logic io_dec(input logic [9:0] a, input logic color);
    io_dec = a >= `IO_LO && a <= `IO_HI;
    if (a <= `IO_MONO_HI && color) io_dec = 1'b0;
    if (a >= `IO_COLOR_LO && !color) io_dec = 1'b0;
  endfunction

  function automatic logic [3:0] byte_en(input logic [1:0] a,
                                         input vga_fe_pkg::fe_cfg_t c);
    if (c.quad_write)
      byte_en = (4'h1 << a) & c.plane_write_mask;
    else if (c.alt_write)
      byte_en = (a[0] ? `BE_ODD : `BE_EVEN) & c.plane_write_mask;
    else
      byte_en = c.plane_write_mask;
  endfunction

  function automatic logic [15:0] fb_addr(input logic [15:0] a,
                                          input vga_fe_pkg::fe_cfg_t c);
    if (c.quad_write)
      fb_addr = {a[15:2], 2'h0};
    else if (c.alt_write)
      fb_addr = {a[15:1], c.page_select_bit};
    else
      fb_addr = a;
  endfunction

  // four-plane pixel unpack, leftmost pixel in the top nibble
  function automatic logic [31:0] unpack(input logic [31:0] d);
    logic [31:0] p;
    p = 32'h0;
    for (int i = 0; i < 8; i++)
      for (int j = 0; j < 4; j++)
        p[(7 - i) * 4 + j] = d[j * 8 + (7 - i)];
    unpack = p;
  endfunction

  assign taken = clk_en && req_valid && req_ready;

  // ------------------------------------------------------------
  // sequencer: split host accesses into byte operations
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      req_ready <= 1'b1;
      cur_addr <= 20'h0;
      wbytes <= 32'h0;
      left <= 2'h0;
      cur_write <= 1'b0;
      cfg <= '0;
    end else if (clk_en) begin
      unique case (state)
        st_idle: begin
          if (taken && !req.is_io && win_hit(req.addr, cfg_in.map_sel)) begin
            state <= st_byte;
            req_ready <= 1'b0;
            cur_addr <= req.addr;
            wbytes <= req.wdata;
            cur_write <= req.write;
            cfg <= cfg_in; // front-end controls only, held per access
            left <= req.size == `SIZE_DWORD ? 2'h3 :
                    req.size == `SIZE_WORD ? 2'h1 : 2'h0;
          end
        end
        st_byte: begin
          if (!cur_write)
            state <= st_wait;
          else begin
            cur_addr <= cur_addr + 20'h1;
            wbytes <= {8'h0, wbytes[31:8]};
            if (left == 2'h0) begin
              state <= st_idle;
              req_ready <= 1'b1;
            end else
              left <= left - 2'h1;
          end
        end
        st_wait: begin
          if (fb_rvalid) begin
            if (left == 2'h0) begin
              state <= st_idle;
              req_ready <= 1'b1;
            end else begin
              // step only after the return: alt read plane needs this byte
              cur_addr <= cur_addr + 20'h1;
              left <= left - 2'h1;
              state <= st_byte;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // frame buffer command
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fb_valid <= 1'b0;
      fb_cmd <= '0;
    end else if (clk_en) begin
      fb_valid <= state == st_byte;
      if (state == st_byte) begin
        fb_cmd.write <= cur_write;
        fb_cmd.addr <= fb_addr(cur_addr[15:0], cfg);
        fb_cmd.be <= cur_write ? byte_en(cur_addr[1:0], cfg)
                               : `BE_NONE;
        fb_cmd.wdata <= {4{wbytes[7:0]}}; // byte on every plane
      end
    end
  end

  // ------------------------------------------------------------
  // read return: whole dword arrives, one plane and the unpacked pixels go back
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h0;
      rd_pixels <= 32'h0;
    end else if (clk_en) begin
      rd_valid <= state == st_wait && fb_rvalid;
      if (state == st_wait && fb_rvalid) begin
        rd_pixels <= unpack(fb_rdata);
        unique case (cfg.alt_read ? {cfg.read_plane[1], cur_addr[0]}
                                  : cfg.read_plane)
          2'h0: rd_data <= fb_rdata[7:0];
          2'h1: rd_data <= fb_rdata[15:8];
          2'h2: rd_data <= fb_rdata[23:16];
          2'h3: rd_data <= fb_rdata[31:24];
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // io decode, index capture, trap and pass-through
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      io_hit <= 1'b0;
      io_is_data <= 1'b0;
      io_addr <= 10'h0;
      io_index <= 8'h0;
      sysmem_pass <= 1'b0;
      ext_bus_start <= 1'b0;
      system_mgmt_interrupt_pin <= 1'b0;
    end else if (clk_en) begin
      io_hit <= taken && req.is_io && io_dec(req.addr[9:0], cfg_in.color_io);
      io_is_data <= req.addr[0];
      io_addr <= req.addr[9:0];
      if (taken && req.is_io && io_dec(req.addr[9:0], cfg_in.color_io)
          && req.write && !req.addr[0])
        io_index <= req.wdata[7:0]; // index port, data port follows
      // trap only emulated hardware; never leave the chip
      system_mgmt_interrupt_pin <= taken &&
        (req.is_io ? io_dec(req.addr[9:0], cfg_in.color_io)
                   : win_hit(req.addr, cfg_in.map_sel));
      sysmem_pass <= taken && !req.is_io &&
                     !win_hit(req.addr, cfg_in.map_sel);
      ext_bus_start <= taken && !req.is_io &&
                       !win_hit(req.addr, cfg_in.map_sel);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_word_split_order: assert property (
    taken && !req.is_io && req.write && req.size == `SIZE_WORD &&
    win_hit(req.addr, cfg_in.map_sel) && !cfg_in.quad_write &&
    !cfg_in.alt_write && clk_en ##1 clk_en[*2]
    |-> fb_valid && fb_cmd.addr == $past(req.addr[15:0], 2) ##1
        fb_valid && fb_cmd.addr == $past(req.addr[15:0], 3) + 16'h1)
    else $error("word write not split into two ordered bytes");
  a_quad_one_enable: assert property (
    fb_valid && fb_cmd.write && cfg.quad_write
    |-> $countones(fb_cmd.be) <= 1 && fb_cmd.addr[1:0] == 2'h0)
    else $error("quad write enable or address wrong");
  a_mask_gates_be: assert property (
    fb_valid && fb_cmd.write |-> (fb_cmd.be & ~cfg.plane_write_mask) == 4'h0)
    else $error("enable outside plane mask");
  // only a freshly issued byte: a frozen edge repeats the old command
  a_alt_write_map: assert property (
    $past(clk_en) && fb_valid && fb_cmd.write && cfg.alt_write &&
    !cfg.quad_write
    |-> fb_cmd.addr[0] == cfg.page_select_bit &&
        (fb_cmd.be & ($past(cur_addr[0]) ? `BE_EVEN : `BE_ODD)) == 4'h0)
    else $error("alternating write mapping wrong");
  a_read_no_be: assert property (
    fb_valid && !fb_cmd.write |-> fb_cmd.be == `BE_NONE)
    else $error("read carries byte enables");
  a_trap_on_window: assert property (
    taken && !req.is_io && win_hit(req.addr, cfg_in.map_sel) && clk_en
    |=> system_mgmt_interrupt_pin && !sysmem_pass && !ext_bus_start)
    else $error("display access not trapped");
  a_pass_outside: assert property (
    taken && !req.is_io && !win_hit(req.addr, cfg_in.map_sel) && clk_en
    |=> sysmem_pass && !system_mgmt_interrupt_pin)
    else $error("outside access trapped or dropped");
  a_io_range_only: assert property (
    io_hit |-> io_addr >= `IO_LO && io_addr <= `IO_HI)
    else $error("io hit outside register range");
  a_busy_until_done: assert property (
    state != st_idle |-> !req_ready)
    else $error("new request accepted mid split");
  a_byte_write_done: assert property (
    taken && !req.is_io && req.write && req.size == `SIZE_BYTE &&
    win_hit(req.addr, cfg_in.map_sel) ##1 clk_en |=> req_ready)
    else $error("byte write left the sequencer busy");
  a_io_trap_hit: assert property (
    taken && req.is_io && io_dec(req.addr[9:0], cfg_in.color_io)
    |=> system_mgmt_interrupt_pin && io_hit)
    else $error("decoded io access not trapped");
  a_io_refused: assert property (
    taken && req.is_io && !io_dec(req.addr[9:0], cfg_in.color_io)
    |=> !io_hit && !system_mgmt_interrupt_pin)
    else $error("refused io port answered");
  a_io_stays_local: assert property (
    taken && req.is_io |=> !ext_bus_start && !sysmem_pass)
    else $error("io access left the chip");
  a_read_one_return: assert property (
    $past(clk_en) && rd_valid |-> $past(fb_rvalid))
    else $error("read data without a frame buffer return");
endmodule // vga_front_end

// ### testbench/fb_model.sv
// frame buffer memory model facing the display front end
`timescale 1ns/1ps
module fb_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic fb_valid,
  input wire vga_fe_pkg::fb_cmd_t fb_cmd,
  output logic fb_rvalid,
  output logic [31:0] fb_rdata
);
  bit [31:0] mem [65536];
  logic [15:0] ra;
  int wait_n;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fb_rvalid <= 1'b0;
      fb_rdata <= 32'h0;
      wait_n <= 0;
    end else if (clk_en) begin
      fb_rvalid <= 1'b0;
      // released data bus shows junk, not the last value
      if (fb_rvalid) fb_rdata <= ~fb_rdata;
      if (wait_n > 0) wait_n <= wait_n - 1;
      if (fb_valid && fb_cmd.write) begin
        for (int i = 0; i < 4; i++)
          if (fb_cmd.be[i])
            mem[fb_cmd.addr][i*8+:8] <= fb_cmd.wdata[i*8+:8];
      end else if (fb_valid) begin
        ra <= fb_cmd.addr;
        wait_n <= 1 + $urandom_range(2);
      end
      if (wait_n == 1) begin
        fb_rvalid <= 1'b1;
        fb_rdata <= mem[ra];
      end
    end
  end
endmodule // fb_model

// ### testbench/vga_frame_buffer_front_end_tb_top.sv
// self-checking bench for the display front end
`timescale 1ns/1ps
module vga_frame_buffer_front_end_tb_top;
  logic mclk = 0, nrst = 0, req_valid = 0, fb_rvalid, req_ready, fb_valid;
  logic rd_valid, io_hit, io_is_data, sysmem_pass, ext_bus_start, smi;
  logic [31:0] fb_rdata, rd_pixels, d;
  logic [7:0] rd_data, io_index, idx = 8'h0;
  logic [9:0] io_addr;
  logic [19:0] a;
  logic [1:0] sz;
  logic wr, h;
  logic ce = 1'b1, ce_seen = 1'b1, stall = 1'b0;
  vga_fe_pkg::host_req_t req = '0;
  vga_fe_pkg::fe_cfg_t cfg = '0;
  vga_fe_pkg::fb_cmd_t fb_cmd;
  vga_fe_pkg::fb_cmd_t fbq[$];
  logic [10:0] ioq[$];
  logic [39:0] rdq[$];
  bit [31:0] sh [65536];
  int err_total = 0, checked = 0, cyc = 0, n_sys, n_ext, n_smi;
  logic [1:0] cm [8] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0, 2'h3};
  logic [19:0] ca [8] = '{20'ha0000, 20'hafffe, 20'hb0000, 20'hb7ffe,
    20'hb8000, 20'hbfffe, 20'h9fffe, 20'hb7ffe};
  logic [9:0] pt [6] = '{10'h3b4, 10'h3b5, 10'h3d4, 10'h3d5, 10'h3c0, 10'h3e0};
  always #5 mclk = ~mclk;
  vga_front_end u_vga_front_end (.mclk(mclk), .nrst(nrst), .clk_en(ce),
    .req_valid(req_valid), .req(req), .cfg_in(cfg), .fb_rvalid(fb_rvalid),
    .fb_rdata(fb_rdata), .req_ready(req_ready), .fb_valid(fb_valid),
    .fb_cmd(fb_cmd), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_pixels(rd_pixels), .io_hit(io_hit), .io_is_data(io_is_data),
    .io_addr(io_addr), .io_index(io_index), .sysmem_pass(sysmem_pass),
    .ext_bus_start(ext_bus_start), .system_mgmt_interrupt_pin(smi));
  fb_model u_fb_model (.mclk(mclk), .nrst(nrst), .clk_en(ce),
    .fb_valid(fb_valid),
    .fb_cmd(fb_cmd), .fb_rvalid(fb_rvalid), .fb_rdata(fb_rdata));
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  always @(posedge mclk) ce_seen <= ce;
  // pulses stand one enabled cycle; frozen edges would repeat them
  always @(negedge mclk) begin
    if (ce_seen === 1'b1) begin
      if (fb_valid === 1'b1) fbq.push_back(fb_cmd);
      if (io_hit === 1'b1) ioq.push_back({io_is_data, io_addr});
      if (rd_valid === 1'b1) rdq.push_back({rd_data, rd_pixels});
      n_sys += (sysmem_pass === 1'b1);
      n_ext += (ext_bus_start === 1'b1);
      n_smi += (smi === 1'b1);
    end
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [3:0] ebe(logic [19:0] x);
    if (cfg.quad_write) return cfg.plane_write_mask & (4'h1 << x[1:0]);
    if (cfg.alt_write) return cfg.plane_write_mask & (x[0] ? 4'ha : 4'h5);
    return cfg.plane_write_mask;
  endfunction
  function automatic logic [15:0] efa(logic [19:0] x);
    if (cfg.quad_write) return {x[15:2], 2'h0};
    if (cfg.alt_write) return {x[15:1], cfg.page_select_bit};
    return x[15:0];
  endfunction
  function automatic bit inwin(logic [19:0] x);
    case (cfg.map_sel)
      2'h1: return x[19:16] == 4'ha;
      2'h2: return x[19:15] == 5'h16;
      2'h3: return x[19:15] == 5'h17;
      default: return x[19:17] == 3'h5;
    endcase
  endfunction
  function automatic logic [1:0] rpl(logic [19:0] x);
    return cfg.alt_read ? {cfg.read_plane[1], x[0]} : cfg.read_plane;
  endfunction
  function automatic logic [31:0] pix(logic [31:0] e);
    for (int p = 0; p < 8; p++)
      for (int b = 0; b < 4; b++) pix[28-4*p+b] = e[b*8+7-p];
  endfunction
  task automatic op(input logic io);
    int k;
    fbq = {};
    ioq = {};
    rdq = {};
    n_sys = 0;
    n_ext = 0;
    n_smi = 0;
    req = '{io, wr, sz, a, d};
    req_valid = 1'b1;
    ce = 1'b1;
    for (k = 0; k < 99 && !req_ready; k++) @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    for (k = 0; k < 99 && req_ready !== 1'b1; k++) begin
      ce = stall ? 1'($urandom_range(1)) : 1'b1;
      @(negedge mclk);
    end
    ce = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  task automatic mem_op();
    logic [15:0] f;
    logic [3:0] be;
    op(1'b0);
    if (!inwin(a)) begin
      chk({n_sys[3:0], n_ext[3:0], n_smi[3:0], 4'(fbq.size())}, 16'h1100);
      return;
    end
    chk({n_sys[3:0], n_ext[3:0], n_smi[3:0]}, 12'h001);
    chk(fbq.size(), wr ? 1 << sz : 1);
    for (int k = 0; k < fbq.size(); k++) begin
      f = efa(a + 20'(k));
      be = wr ? ebe(a + 20'(k)) : 4'h0;
      chk({fbq[k].write, fbq[k].addr, fbq[k].be}, {wr, f, be});
      if (wr) chk(fbq[k].wdata, {4{d[k*8+:8]}});
      for (int j = 0; j < 4; j++) if (wr && be[j]) sh[f][j*8+:8] = d[k*8+:8];
    end
    if (!wr) begin
      f = efa(a);
      chk(rdq.size(), 1);
      chk(rdq[0], {sh[f][rpl(a)*8+:8], pix(sh[f])});
    end
  endtask
  initial begin
    void'($urandom(93244));
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    cfg.plane_write_mask = 4'hf;
    wr = 1'b1;
    sz = 2'h1;
    d = 32'hc3a55a3c;
    for (int i = 0; i < 8; i++) begin
      cfg.map_sel = cm[i];
      a = ca[i];
      mem_op();
    end
    cfg.map_sel = 2'h0;
    cfg.quad_write = 1'b1;
    cfg.plane_write_mask = 4'hd;
    sz = 2'h2;
    a = 20'ha0004;
    mem_op();
    cfg.quad_write = 1'b0;
    cfg.alt_write = 1'b1;
    cfg.page_select_bit = 1'b1;
    mem_op();
    cfg.alt_write = 1'b0;
    wr = 1'b0;
    sz = 2'h0;
    for (int p = 0; p < 4; p++) begin
      cfg.read_plane = 2'(p);
      a = 20'ha0004 + 20'(p);
      mem_op();
    end
    cfg.alt_read = 1'b1;
    cfg.read_plane = 2'h2;
    for (int p = 0; p < 2; p++) begin
      a = 20'ha0004 + 20'(p);
      mem_op();
    end
    // random mix with clock-enable stalls; reads keep write modes off
    stall = 1'b1;
    repeat (60) begin
      cfg = vga_fe_pkg::fe_cfg_t'(13'($urandom));
      wr = $urandom_range(3) != 0;
      sz = wr ? 2'($urandom_range(2)) : 2'h0;
      if (!wr) cfg.quad_write = 1'b0;
      if (!wr) cfg.alt_write = 1'b0;
      a = (20'h90000 + 20'($urandom_range(20'h3ffff))) & ~((20'h1 << sz) - 20'h1);
      d = $urandom;
      mem_op();
    end
    stall = 1'b0;
    wr = 1'b1;
    sz = 2'h0;
    for (int c = 0; c < 2; c++)
      for (int i = 0; i < 6; i++) begin
        cfg.color_io = c[0];
        a = {10'h0, pt[i]};
        d = $urandom;
        op(1'b1);
        h = pt[i] >= 10'h3b0 && pt[i] <= 10'h3df &&
          pt[i][9:4] != (c ? 6'h3b : 6'h3d);
        chk({4'(ioq.size()), n_smi[3:0], n_sys[3:0], n_ext[3:0]},
          {3'h0, h, 3'h0, h, 8'h0});
        if (h) chk(ioq[0], {pt[i][0], pt[i]});
        if (h && !pt[i][0]) idx = d[7:0];
        chk(io_index, idx);
      end
    finish_test();
  end
endmodule // vga_frame_buffer_front_end_tb_top
